// [src/pcg_pkg.sv]
package pcg_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam int unsigned WARN_HOLD_MS = 60_000;
  localparam int unsigned SYNC_DELAY_MS = 2;
  localparam int unsigned SYNC_MAX_MS = 5;
  localparam int unsigned FLASH_MS = 250;
  localparam logic [1:0] SETTLE_CYC = 2'h2;
  // ----------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_TXTYPE = 5'h00;
  localparam logic [4:0] ADDR_CONFIG = 5'h04;
  localparam logic [4:0] ADDR_STATUS = 5'h08;
  localparam logic [4:0] ADDR_SLOT0 = 5'h10;
  localparam int unsigned CFG_NODE_LSB = 0;
  localparam int unsigned CFG_RATE_LSB = 8;
  localparam int unsigned CFG_COUNT_LSB = 12;
  localparam int unsigned CFG_FAST_BIT = 16;
  localparam int unsigned CFG_NODEZERO_BIT = 17;
  localparam int unsigned ST_CODE_LSB = 0;
  localparam int unsigned ST_ERR_BIT = 4;
  localparam int unsigned ST_WARN_BIT = 5;
  localparam int unsigned ST_POLL_LSB = 8;
  localparam int unsigned ST_CFG_BIT = 10;
  localparam logic [3:0] TXTYPE_RST = 4'h0;
  // ----------------------------------------------------------------
  // pause switch settings and event codes
  // ----------------------------------------------------------------
  localparam logic [3:0] PAUSE_ASYNC_MAX = 4'hB;
  localparam logic [3:0] PAUSE_SYNC = 4'hD;
  localparam logic [3:0] PAUSE_E = 4'hE;
  localparam logic [3:0] PAUSE_F = 4'hF;
  localparam logic [3:0] ERR_MAX = 4'h7;
  localparam logic [3:0] WARN_MIN = 4'h8;
  typedef enum logic {POLL_IDLE, POLL_WAIT} pcg_poll_t;

  // least pause in ms for a pause setting
  function automatic logic [7:0] minPauseMs(input logic [3:0] s);
    case (s)
      4'h0: minPauseMs = 8'h03;
      4'h1: minPauseMs = 8'h05;
      4'h2: minPauseMs = 8'h0A;
      4'h3: minPauseMs = 8'h0F;
      4'h4: minPauseMs = 8'h14;
      4'h5: minPauseMs = 8'h1E;
      4'h6: minPauseMs = 8'h28;
      4'h7: minPauseMs = 8'h32;
      4'h8: minPauseMs = 8'h64;
      4'h9: minPauseMs = 8'h96;
      4'hA: minPauseMs = 8'hC8;
      4'hB: minPauseMs = 8'hFA;
      4'hE: minPauseMs = 8'h05;
      4'hF: minPauseMs = 8'h03;
      default: minPauseMs = 8'h00;
    endcase
  endfunction : minPauseMs

  // longest silence in ms for the refreshing settings
  function automatic logic [7:0] maxPauseMs(input logic [3:0] s);
    case (s)
      4'hE: maxPauseMs = 8'h32;
      4'hF: maxPauseMs = 8'h14;
      default: maxPauseMs = 8'h00;
    endcase
  endfunction : maxPauseMs

  function automatic logic isAsync(input logic [3:0] s);
    isAsync = (s <= PAUSE_ASYNC_MAX) || (s == PAUSE_E) || (s == PAUSE_F);
  endfunction : isAsync
endpackage : pcg_pkg

// [src/pcg_slot_store.sv]
`timescale 1ns/1ps
module pcg_slot_store #(
  parameter int unsigned DataW = 32,
  parameter int unsigned Slots = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // write side with change report
  input wire logic wrEn,
  input wire logic [$clog2(Slots)-1:0] wrSlot,
  input wire logic [DataW-1:0] wrData,
  output logic changed,
  // registered read side
  input wire logic rdSel,
  input wire logic [$clog2(Slots)-1:0] rdSlot,
  input wire logic [DataW-1:0] rdAltData,
  output logic [DataW-1:0] rdData
);
  logic [DataW-1:0] mem [Slots];

  // slots never written stay zero, so unconfigured readers read as zero
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < Slots; i++) begin
        mem[i] <= '0;
      end
      changed <= 1'b0;
      rdData <= '0;
    end else begin
      if (wrEn) begin
        mem[wrSlot] <= wrData;
      end
      changed <= wrEn && (mem[wrSlot] != wrData);
      rdData <= rdSel ? mem[rdSlot] : rdAltData;
    end
  end
endmodule : pcg_slot_store

// [src/pcg_tx_sched.sv]
`timescale 1ns/1ps
module pcg_tx_sched #(
  parameter int unsigned MsCycles = pcg_pkg::CYC_PER_MS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic [3:0] txType,
  input wire logic dataChanged,
  input wire logic syncRx,
  // results
  output logic txReq,
  output logic msTick
);
  localparam int unsigned CW = $clog2(MsCycles);
  localparam logic [2:0] SYNC_TICKS = 3'(pcg_pkg::SYNC_DELAY_MS);
  logic [CW-1:0] preCnt_q;
  logic [7:0] sinceTx_q;
  logic pending_q;
  logic syncWait_q;
  logic [2:0] syncCnt_q;
  logic syncMode;
  logic restart;
  logic txFire;

  // restarting the ms prescaler on each send makes pause counts exact
  assign syncMode = (txType == pcg_pkg::PAUSE_SYNC);
  assign txFire = run && (
    (pcg_pkg::isAsync(txType) && pending_q && sinceTx_q >= pcg_pkg::minPauseMs(txType))
    || ((txType == pcg_pkg::PAUSE_E || txType == pcg_pkg::PAUSE_F)
        && sinceTx_q >= pcg_pkg::maxPauseMs(txType))
    || (syncMode && syncWait_q && syncCnt_q == SYNC_TICKS));
  assign restart = txFire || (syncMode && syncRx);

  // ms prescaler
  always_ff @(posedge clk) begin
    if (rst || restart) begin
      preCnt_q <= '0;
    end else if (preCnt_q == CW'(MsCycles - 1)) begin
      preCnt_q <= '0;
    end else begin
      preCnt_q <= preCnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      msTick <= 1'b0;
    end else begin
      msTick <= !restart && (preCnt_q == CW'(MsCycles - 1));
    end
  end

  // ms since the last send, saturating
  always_ff @(posedge clk) begin
    if (rst) begin
      sinceTx_q <= 8'hFF;
    end else if (txFire) begin
      sinceTx_q <= 8'h00;
    end else if (msTick && sinceTx_q != 8'hFF) begin
      sinceTx_q <= sinceTx_q + 8'h01;
    end
  end

  // a change seen in the sending cycle stays pending
  always_ff @(posedge clk) begin
    if (rst) begin
      pending_q <= 1'b0;
    end else begin
      pending_q <= dataChanged || (pending_q && !txFire);
    end
  end

  // delay after a bus sync message
  always_ff @(posedge clk) begin
    if (rst) begin
      syncWait_q <= 1'b0;
      syncCnt_q <= 3'h0;
    end else if (syncMode && syncRx) begin
      syncWait_q <= 1'b1;
      syncCnt_q <= 3'h0;
    end else if (txFire || !syncMode) begin
      syncWait_q <= 1'b0;
    end else if (syncWait_q && msTick) begin
      syncCnt_q <= syncCnt_q + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      txReq <= 1'b0;
    end else begin
      txReq <= txFire;
    end
  end
endmodule : pcg_tx_sched

// [src/pcg_gateway.sv]
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
// Notes on behaviour
// - count switch gives readers and rate group
// - two switch bits pick bit rate
// - node number is switch field, MSB zero
// - bus indicator shows guarding and bus errors
// - green link, one-hot polled reader display
// - event turns link red, shows number
// - errors 1 to 7 latch until reset
// - warnings 8 to 15 clear after minute
// - async: send on change, honour least pause
// - unchanged position sends nothing further
// - E/F also refresh at longest interval
// - transmission type preset, master may change
// - bus slave, rates up to 1 MBaud
// - sync mode sends two ms after sync
// - unconfigured reader slots read zero
module pcg_gateway #(
  parameter int unsigned MsCycles = pcg_pkg::CYC_PER_MS,
  parameter int unsigned WarnHoldMs = pcg_pkg::WARN_HOLD_MS,
  parameter int unsigned FlashMs = pcg_pkg::FLASH_MS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration switches
  input wire logic [3:0] readerCountSw,
  input wire logic [1:0] rateSw,
  input wire logic [5:0] nodeSw,
  input wire logic [3:0] pauseSw,
  // register port
  input wire logic [4:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  // reader link framer
  output logic pollReq,
  output logic [1:0] pollAddr,
  input wire logic rdValid,
  input wire logic [31:0] rdData,
  input wire logic rdEvt,
  input wire logic [3:0] rdEvtCode,
  // bus protocol side
  input wire logic guardActive,
  input wire logic guardError,
  input wire logic busError,
  input wire logic syncRx,
  output logic txReq,
  output logic fastRateGroup,
  output logic [2:0] bitRateSel,
  output logic [6:0] nodeNumber,
  // indicators
  output logic busLedGreen,
  output logic busLedRed,
  output logic linkLedGreen,
  output logic linkLedRed,
  output logic [3:0] codeLeds
);
  // ----------------------------------------------------------------
  // switch capture
  // ----------------------------------------------------------------
  logic [15:0] swMeta_q;
  logic [15:0] swSync_q;
  logic [1:0] settle_q;
  logic cfgLoaded_q;
  logic [2:0] readerCnt_q;
  logic [3:0] txType_q;
  logic [3:0] cntSw;
  logic [1:0] rateBits;
  logic [5:0] nodeBits;
  logic [3:0] pauseBits;

  assign cntSw = swSync_q[15:12];
  assign rateBits = swSync_q[11:10];
  assign nodeBits = swSync_q[9:4];
  assign pauseBits = swSync_q[3:0];

  // switches are pins: two flops before anything looks at them
  always_ff @(posedge clk) begin
    swMeta_q <= {readerCountSw, rateSw, nodeSw, pauseSw};
    swSync_q <= swMeta_q;
  end

  // wait for the synchroniser to fill, then capture once
  always_ff @(posedge clk) begin
    if (rst) begin
      settle_q <= 2'h0;
      cfgLoaded_q <= 1'b0;
    end else if (!cfgLoaded_q) begin
      settle_q <= settle_q + 2'h1;
      cfgLoaded_q <= (settle_q == pcg_pkg::SETTLE_CYC);
    end
  end

  // decoded settings only change at the capture cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      readerCnt_q <= 3'h0;
      fastRateGroup <= 1'b0;
      bitRateSel <= 3'h0;
      nodeNumber <= 7'h00;
    end else if (!cfgLoaded_q && settle_q == pcg_pkg::SETTLE_CYC) begin
      if (cntSw >= 4'h1 && cntSw <= 4'h4) begin
        readerCnt_q <= cntSw[2:0];
        fastRateGroup <= 1'b1;
      end else if (cntSw >= 4'h5 && cntSw <= 4'h8) begin
        readerCnt_q <= 3'(cntSw - 4'h4);
        fastRateGroup <= 1'b0;
      end else begin
        readerCnt_q <= 3'h0;
        fastRateGroup <= 1'b0;
      end
      // index 0..3: 1M, 500k, 250k, 125k; 4..7: 100k, 50k, 20k, 10k
      bitRateSel <= {!(cntSw >= 4'h1 && cntSw <= 4'h4), rateBits};
      nodeNumber <= {1'b0, nodeBits};
    end
  end

  // transmission type: preset from the pause switch, master may rewrite
  always_ff @(posedge clk) begin
    if (rst) begin
      txType_q <= pcg_pkg::TXTYPE_RST;
    end else if (!cfgLoaded_q && settle_q == pcg_pkg::SETTLE_CYC) begin
      txType_q <= pauseBits;
    end else if (regWr && regAddr == pcg_pkg::ADDR_TXTYPE) begin
      txType_q <= regWrData[3:0];
    end
  end

  // ----------------------------------------------------------------
  // reader polling
  // ----------------------------------------------------------------
  pcg_pkg::pcg_poll_t pollState_q;
  logic rdDone;
  logic slotChanged;
  logic msTick;

  assign rdDone = (pollState_q == pcg_pkg::POLL_WAIT) && (rdValid || rdEvt);

  // one request per reader; the framer answers with data or an event
  always_ff @(posedge clk) begin
    if (rst) begin
      pollState_q <= pcg_pkg::POLL_IDLE;
      pollReq <= 1'b0;
      pollAddr <= 2'h0;
    end else begin
      pollReq <= 1'b0;
      case (pollState_q)
        pcg_pkg::POLL_IDLE: begin
          if (cfgLoaded_q && readerCnt_q != 3'h0) begin
            pollReq <= 1'b1;
            pollState_q <= pcg_pkg::POLL_WAIT;
          end
        end
        pcg_pkg::POLL_WAIT: begin
          if (rdValid || rdEvt) begin
            pollState_q <= pcg_pkg::POLL_IDLE;
            pollAddr <= ({1'b0, pollAddr} == readerCnt_q - 3'h1) ? 2'h0 : pollAddr + 2'h1;
          end
        end
        default: pollState_q <= pcg_pkg::POLL_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register read path through the slot store
  // ----------------------------------------------------------------
  logic slotHit;
  logic [31:0] regVal;

  assign slotHit = regRd && (regAddr[4] == pcg_pkg::ADDR_SLOT0[4]);

  logic errLatched_q;
  logic warnActive_q;
  logic [3:0] errCode_q;
  logic [3:0] warnCode_q;

  always_comb begin
    regVal = 32'h0000_0000;
    if (regRd) begin
      case (regAddr)
        pcg_pkg::ADDR_TXTYPE: regVal[3:0] = txType_q;
        pcg_pkg::ADDR_CONFIG: begin
          regVal[pcg_pkg::CFG_NODE_LSB +: 7] = nodeNumber;
          regVal[pcg_pkg::CFG_RATE_LSB +: 3] = bitRateSel;
          regVal[pcg_pkg::CFG_COUNT_LSB +: 3] = readerCnt_q;
          regVal[pcg_pkg::CFG_FAST_BIT] = fastRateGroup;
          regVal[pcg_pkg::CFG_NODEZERO_BIT] = (nodeNumber == 7'h00);
        end
        pcg_pkg::ADDR_STATUS: begin
          regVal[pcg_pkg::ST_CODE_LSB +: 4] = codeLeds;
          regVal[pcg_pkg::ST_ERR_BIT] = errLatched_q;
          regVal[pcg_pkg::ST_WARN_BIT] = warnActive_q;
          regVal[pcg_pkg::ST_POLL_LSB +: 2] = pollAddr;
          regVal[pcg_pkg::ST_CFG_BIT] = cfgLoaded_q;
        end
        default: regVal = 32'h0000_0000;
      endcase
    end
  end

  // only configured slots are ever written, others stay zero
  pcg_slot_store #(.DataW(32), .Slots(4)) u_store (
    .clk(clk),
    .rst(rst),
    .wrEn(rdDone && rdValid && ({1'b0, pollAddr} < readerCnt_q)),
    .wrSlot(pollAddr),
    .wrData(rdData),
    .changed(slotChanged),
    .rdSel(slotHit),
    .rdSlot(regAddr[3:2]),
    .rdAltData(regVal),
    .rdData(regRdData)
  );

  pcg_tx_sched #(.MsCycles(MsCycles)) u_sched (
    .clk(clk),
    .rst(rst),
    .run(cfgLoaded_q),
    .txType(txType_q),
    .dataChanged(slotChanged),
    .syncRx(syncRx),
    .txReq(txReq),
    .msTick(msTick)
  );

  // ----------------------------------------------------------------
  // errors and warnings
  // ----------------------------------------------------------------
  logic [15:0] warnMs_q;
  logic newWarn;

  assign newWarn = rdEvt && rdEvtCode >= pcg_pkg::WARN_MIN;

  // first error wins and stays until reset; no recovery path exists
  always_ff @(posedge clk) begin
    if (rst) begin
      errLatched_q <= 1'b0;
      errCode_q <= 4'h0;
    end else if (rdEvt && !errLatched_q && rdEvtCode != 4'h0 && rdEvtCode <= pcg_pkg::ERR_MAX) begin
      errLatched_q <= 1'b1;
      errCode_q <= rdEvtCode;
    end
  end

  // a fresh warning restarts the minute and beats the expiry
  always_ff @(posedge clk) begin
    if (rst) begin
      warnActive_q <= 1'b0;
      warnCode_q <= 4'h0;
      warnMs_q <= 16'h0000;
    end else if (newWarn) begin
      warnActive_q <= 1'b1;
      warnCode_q <= rdEvtCode;
      warnMs_q <= 16'h0000;
    end else if (warnActive_q && msTick) begin
      if (warnMs_q == 16'(WarnHoldMs - 1)) begin
        warnActive_q <= 1'b0;
      end else begin
        warnMs_q <= warnMs_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // indicators
  // ----------------------------------------------------------------
  logic [15:0] flashMs_q;
  logic flashPhase_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      flashMs_q <= 16'h0000;
      flashPhase_q <= 1'b0;
    end else if (msTick) begin
      if (flashMs_q == 16'(FlashMs - 1)) begin
        flashMs_q <= 16'h0000;
        flashPhase_q <= !flashPhase_q;
      end else begin
        flashMs_q <= flashMs_q + 16'h0001;
      end
    end
  end

  // bus error outranks guarding error, which outranks guarding state
  always_ff @(posedge clk) begin
    if (rst) begin
      busLedGreen <= 1'b0;
      busLedRed <= 1'b0;
    end else begin
      busLedGreen <= !busError && !guardError && (guardActive || flashPhase_q);
      busLedRed <= busError ? flashPhase_q : guardError;
    end
  end

  // error over warning over polled-reader display
  always_ff @(posedge clk) begin
    if (rst) begin
      linkLedGreen <= 1'b0;
      linkLedRed <= 1'b0;
      codeLeds <= 4'h0;
    end else if (errLatched_q) begin
      linkLedGreen <= 1'b0;
      linkLedRed <= 1'b1;
      codeLeds <= errCode_q;
    end else if (warnActive_q) begin
      linkLedGreen <= 1'b0;
      linkLedRed <= 1'b1;
      codeLeds <= warnCode_q;
    end else begin
      linkLedRed <= 1'b0;
      linkLedGreen <= cfgLoaded_q && readerCnt_q != 3'h0;
      codeLeds <= (cfgLoaded_q && readerCnt_q != 3'h0) ? (4'h1 << pollAddr) : 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [23:0] txGap_q;
  logic [23:0] syncAge_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      txGap_q <= 24'hFFFFFF;
      syncAge_q <= 24'hFFFFFF;
    end else begin
      txGap_q <= txReq ? 24'h000001 : (txGap_q == 24'hFFFFFF ? txGap_q : txGap_q + 24'h000001);
      syncAge_q <= syncRx ? 24'h000001 : (syncAge_q == 24'hFFFFFF ? syncAge_q : syncAge_q + 24'h000001);
    end
  end

  property p_count_group;
    @(posedge clk) disable iff (rst)
    $rose(cfgLoaded_q) |-> fastRateGroup == ($past(cntSw) >= 4'h1 && $past(cntSw) <= 4'h4);
  endproperty
  a_count_group: assert property (p_count_group) else $error("rate group wrong");

  property p_rate;
    @(posedge clk) disable iff (rst)
    $rose(cfgLoaded_q) |-> bitRateSel[1:0] == $past(rateBits);
  endproperty
  a_rate: assert property (p_rate) else $error("bit rate code wrong");

  property p_node;
    @(posedge clk) disable iff (rst)
    $rose(cfgLoaded_q) |-> nodeNumber == {1'b0, $past(nodeBits)};
  endproperty
  a_node: assert property (p_node) else $error("node number wrong");

  property p_cfg_stable;
    @(posedge clk) disable iff (rst)
    cfgLoaded_q && $past(cfgLoaded_q) |-> $stable(nodeNumber) && $stable(bitRateSel) && $stable(fastRateGroup);
  endproperty
  a_cfg_stable: assert property (p_cfg_stable) else $error("settings changed in operation");

  property p_guard_err;
    @(posedge clk) disable iff (rst)
    guardError && !busError |=> busLedRed && !busLedGreen;
  endproperty
  a_guard_err: assert property (p_guard_err) else $error("guard error not shown red");

  property p_onehot;
    @(posedge clk) disable iff (rst)
    linkLedGreen |-> codeLeds == (4'h1 << $past(pollAddr));
  endproperty
  a_onehot: assert property (p_onehot) else $error("polled reader display wrong");

  property p_err_show;
    @(posedge clk) disable iff (rst)
    rdEvt && !errLatched_q && rdEvtCode != 4'h0 && rdEvtCode <= pcg_pkg::ERR_MAX
    |-> ##2 linkLedRed && codeLeds == $past(rdEvtCode, 2);
  endproperty
  a_err_show: assert property (p_err_show) else $error("error number not displayed");

  property p_err_hold;
    @(posedge clk) disable iff (rst)
    errLatched_q |=> errLatched_q && $stable(errCode_q);
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error cleared before reset");

  property p_min_pause;
    @(posedge clk) disable iff (rst)
    txReq && pcg_pkg::isAsync(txType_q) && $stable(txType_q)
    |-> int'(txGap_q) >= int'(pcg_pkg::minPauseMs(txType_q)) * int'(MsCycles);
  endproperty
  a_min_pause: assert property (p_min_pause) else $error("send inside least pause");

  property p_sync_late;
    @(posedge clk) disable iff (rst)
    txReq && txType_q == pcg_pkg::PAUSE_SYNC && $stable(txType_q)
    |-> int'(syncAge_q) <= int'(pcg_pkg::SYNC_MAX_MS) * int'(MsCycles);
  endproperty
  a_sync_late: assert property (p_sync_late) else $error("sync send too late");
endmodule : pcg_gateway

// [sim/pcg_reader_model.sv]
`timescale 1ns/1ps
module pcg_reader_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // poll side from the gateway
  input wire logic pollReq,
  input wire logic [1:0] pollAddr,
  // scenario control
  input wire logic moving,
  input wire logic [3:0] evtCode,
  // answers
  output logic rdValid,
  output logic [31:0] rdData,
  output logic rdEvt,
  output logic [3:0] rdEvtCode
);
  logic [1:0] wait_q;
  logic [21:0] pos_q;
  // answer each poll three cycles later; idle data lines toggle so stale values never match
  always_ff @(posedge clk) begin
    rdValid <= 1'b0;
    rdEvt <= 1'b0;
    rdData <= ~rdData;
    rdEvtCode <= ~rdEvtCode;
    if (rst) begin
      wait_q <= 2'h0;
      pos_q <= 22'h0;
      rdData <= 32'h0;
      rdEvtCode <= 4'h0;
    end else if (pollReq) begin
      wait_q <= 2'h3;
    end else if (wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
      if (wait_q == 2'h1 && evtCode != 4'h0) begin
        rdEvt <= 1'b1;
        rdEvtCode <= evtCode;
      end else if (wait_q == 2'h1) begin
        // address in the low bits keeps each reader's word distinct
        rdValid <= 1'b1;
        rdData <= {pos_q, 8'h00, pollAddr};
        pos_q <= pos_q + {21'h0, moving};
      end
    end
  end
endmodule : pcg_reader_model

// [sim/pcg_gateway_test.sv]
`timescale 1ns/1ps
module pcg_gateway_test;
  localparam int MS = 20;
  logic clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, moving = 1'b0;
  logic [3:0] readerCountSw = 4'h6, pauseSw = 4'hF, evtCode = 4'h0, rdEvtCode, codeLeds;
  logic [1:0] rateSw = 2'h2, pollAddr;
  logic [5:0] nodeSw = 6'h2A; // never zero on the bus
  logic [4:0] regAddr = 5'h00;
  logic [31:0] regWrData = 32'h0, regRdData, rdData, rv;
  logic [2:0] bitRateSel;
  logic [6:0] nodeNumber;
  logic guardActive = 1'b0, guardError = 1'b0, busError = 1'b0, syncRx = 1'b0;
  logic pollReq, rdValid, rdEvt, txReq, fastRateGroup;
  logic busLedGreen, busLedRed, linkLedGreen, linkLedRed;
  int failures = 0, samples_checked = 0, gap = 0, minGap, maxGap, txCount;
  always #25 clk = ~clk;
  pcg_gateway #(.MsCycles(MS), .WarnHoldMs(5), .FlashMs(2)) dut (.clk(clk), .rst(rst),
    .readerCountSw(readerCountSw), .rateSw(rateSw), .nodeSw(nodeSw), .pauseSw(pauseSw),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .pollReq(pollReq), .pollAddr(pollAddr), .rdValid(rdValid), .rdData(rdData), .rdEvt(rdEvt),
    .rdEvtCode(rdEvtCode), .guardActive(guardActive), .guardError(guardError), .busError(busError),
    .syncRx(syncRx), .txReq(txReq), .fastRateGroup(fastRateGroup), .bitRateSel(bitRateSel),
    .nodeNumber(nodeNumber), .busLedGreen(busLedGreen), .busLedRed(busLedRed),
    .linkLedGreen(linkLedGreen), .linkLedRed(linkLedRed), .codeLeds(codeLeds));
  pcg_reader_model reader (.clk(clk), .rst(rst), .pollReq(pollReq), .pollAddr(pollAddr),
    .moving(moving), .evtCode(evtCode), .rdValid(rdValid), .rdData(rdData), .rdEvt(rdEvt),
    .rdEvtCode(rdEvtCode));
  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  // gap statistics between transmit pulses; the first pulse only starts the count
  always @(posedge clk) begin
    gap = gap + 1;
    if (txReq === 1'b1) begin
      if (txCount > 0 && gap < minGap) minGap = gap;
      if (txCount > 0 && gap > maxGap) maxGap = gap;
      txCount = txCount + 1;
      gap = 0;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic regWrite(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : regWrite
  // data stand in the cycle after the strobe, seen at the following edge
  task automatic regRead(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
    d = regRdData;
  endtask : regRead
  task automatic statsClear();
    txCount = 0;
    minGap = 1000000;
    maxGap = 0;
  endtask : statsClear
  task automatic doReset();
    rst <= 1'b1;
    cyc(16);
    rst <= 1'b0;
    cyc(8);
  endtask : doReset
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_config();
    chk(fastRateGroup, 1'b0, "slow group");
    chk(bitRateSel, 3'h6, "rate 20k");
    chk(nodeNumber, 7'h2A, "node");
    readerCountSw <= 4'h2;
    nodeSw <= 6'h01;
    cyc(5);
    regRead(pcg_pkg::ADDR_CONFIG, rv);
    chk(rv, 32'h0000_262A, "config held");
    regRead(5'h0C, rv);
    chk(rv, 32'h0, "unmapped");
    regWrite(pcg_pkg::ADDR_TXTYPE, 32'h0000_0005);
    regRead(pcg_pkg::ADDR_TXTYPE, rv);
    chk(rv, 32'h5, "txtype rw");
    regWrite(pcg_pkg::ADDR_TXTYPE, 32'h0000_000F);
    $display("test_config done");
  endtask : test_config
  task automatic test_poll();
    logic [1:0] seq [4];
    for (int i = 0; i < 4; i++) begin
      @(posedge clk iff pollReq === 1'b1);
      seq[i] = pollAddr;
      cyc(1);
      chk(codeLeds, 4'h1 << pollAddr, "one-hot");
      chk(linkLedGreen, 1'b1, "link green");
    end
    chk({seq[0], seq[1], seq[2], seq[3]}, 8'h11, "rotation");
    regRead(5'h10, rv);
    chk(rv[9:0], 10'h000, "slot 0 addr");
    regRead(5'h18, rv);
    chk(rv, 32'h0, "slot 2 empty");
    regRead(5'h1C, rv);
    chk(rv, 32'h0, "slot 3 empty");
    $display("test_poll done");
  endtask : test_poll
  task automatic test_tx_refresh();
    moving <= 1'b1;
    cyc(100);
    statsClear();
    cyc(600);
    chk(minGap >= 3 * MS, 1'b1, "least pause F");
    chk(maxGap <= 3 * MS + 20, 1'b1, "change driven");
    moving <= 1'b0;
    cyc(100);
    statsClear();
    cyc(1300);
    chk(minGap >= 20 * MS, 1'b1, "refresh not early");
    chk(maxGap <= 20 * MS + 20, 1'b1, "refresh period");
    $display("test_tx_refresh done");
  endtask : test_tx_refresh
  task automatic test_events();
    evtCode <= 4'h9;
    @(posedge clk iff rdEvt === 1'b1);
    evtCode <= 4'h0;
    cyc(5);
    chk({linkLedRed, codeLeds}, 5'h19, "warning shown");
    cyc(60);
    chk(linkLedRed, 1'b1, "warning held");
    cyc(70);
    chk({linkLedRed, linkLedGreen}, 2'h1, "warning cleared");
    evtCode <= 4'h3;
    @(posedge clk iff rdEvt === 1'b1);
    evtCode <= 4'h0;
    cyc(400);
    chk({linkLedRed, codeLeds}, 5'h13, "error latched");
    $display("test_events done");
  endtask : test_events
  task automatic test_bus_led();
    int onCnt, offCnt;
    guardActive <= 1'b1;
    cyc(5);
    chk({busLedGreen, busLedRed}, 2'h2, "guarding");
    guardError <= 1'b1;
    cyc(5);
    chk({busLedGreen, busLedRed}, 2'h1, "guard error");
    busError <= 1'b1;
    onCnt = 0;
    offCnt = 0;
    cyc(3);
    repeat (200) begin
      @(posedge clk);
      if (busLedRed === 1'b1) onCnt++;
      else offCnt++;
    end
    chk(onCnt > 40 && offCnt > 40 && busLedGreen === 1'b0, 1'b1, "red flash");
    {guardActive, guardError, busError} <= 3'h0;
    $display("test_bus_led done");
  endtask : test_bus_led
  task automatic test_sync();
    regWrite(pcg_pkg::ADDR_TXTYPE, 32'h0000_000D);
    cyc(4);
    statsClear();
    cyc(400);
    chk(txCount, 0, "no send before sync");
    syncRx <= 1'b1;
    cyc(1);
    syncRx <= 1'b0;
    cyc(5 * MS);
    chk(txCount, 1, "send after sync");
    $display("test_sync done");
  endtask : test_sync
  task automatic test_quiet();
    readerCountSw <= 4'h3;
    rateSw <= 2'h1;
    pauseSw <= 4'h2;
    nodeSw <= 6'h15;
    doReset();
    chk({fastRateGroup, bitRateSel, nodeNumber}, 11'h495, "fast config");
    chk(linkLedRed, 1'b0, "error gone after reset");
    cyc(500);
    statsClear();
    cyc(1000);
    chk(txCount, 0, "quiet when unchanged");
    $display("test_quiet done");
  endtask : test_quiet
  initial begin
    statsClear();
    doReset();
    test_config();
    test_poll();
    test_tx_refresh();
    test_events();
    test_bus_led();
    test_sync();
    test_quiet();
    complete_run();
  end
  // watchdog well beyond the expected length of the run
  initial begin
    #(20000 * 50);
    failures++;
    complete_run();
  end
endmodule : pcg_gateway_test
